// ===== shared/quick_setup_pkg.sv
// Constants, indices and carrier types of the quick-setup parameter menu
// Operation
// RL1: Menu closes after 30 s without any key press; operator re-enters from start.
// RL2: Written values act at once; persistence only after a save command.
// RL3: Save code 1 stores, 2 stores and restarts, 3 restarts, 10 restores defaults.
// RL4: After a save, loop settings are recomputed from load type and application.
// RL5: Rightmost command-type digit: 0 dual pulse, 1 pulse/direction, 2 quadrature, 8 host.
// RL6: Types 0..2 force working mode -4; type 8 leaves mode to the link.
// RL7: Host mode removes enable, error clear and homing from inputs one to three.
// RL8: Gear numerator and denominator apply only in the three pulse formats.
// RL9: Gear values shown decimal, hexadecimal once above 9999.
// RL10: Fresh drive learns a valid motor identity; unknown motor makes display flash.
// RL11: Used drive compares motor with stored one; mismatch raises flashing fault.
// RL12: Mechanics digits one, two: load type and application, both steer tuning; the presets here use only the load type.
// RL13: Digit three limit-switch handling, digit four fault-output polarity.
// RL14: Pulse modes map inputs to enable, clear, homing, limits and home sensor.
// RL15: Outputs map to ready, brake, position reached, zero speed and error.
// RL16: Finishing quick setup presets stiffness and inertia ratio from mechanics.
// RL17: Operator may write a known inertia ratio directly; measuring is better.
// RL18: Out-of-range value or enabled drive rejects a change with a failure flag.
// RL19: Tuning-method write of 1 enables controller and starts inertia measurement.
// RL20: Undefined save codes are ignored with no effect.
package quick_setup_pkg;

  // Parameter indices on the parameter port
  localparam logic [3:0] IDX_SAVE_COMMAND    = 4'h0;
  localparam logic [3:0] IDX_MOTOR_MODEL     = 4'h1;
  localparam logic [3:0] IDX_COMMAND_TYPE    = 4'h2;
  localparam logic [3:0] IDX_GEAR_NUMERATOR  = 4'h3;
  localparam logic [3:0] IDX_GEAR_DENOMINATR = 4'h4;
  localparam logic [3:0] IDX_MECHANICS       = 4'h6;
  localparam logic [3:0] IDX_HOMING_METHOD   = 4'h7;
  localparam logic [3:0] IDX_INERTIA_RATIO   = 4'h9;
  localparam logic [3:0] IDX_TUNING_METHOD   = 4'ha;
  localparam logic [3:0] IDX_STIFFNESS       = 4'hb;

  // Reset values
  localparam logic [15:0] RST_COMMAND_TYPE = 16'h0001;
  localparam logic [31:0] RST_GEAR         = 32'h0000_03e8;
  localparam logic [15:0] RST_MECHANICS    = 16'h1001;
  localparam logic [15:0] RST_HOMING       = 16'h0000;
  localparam logic [15:0] RST_MOTOR_MODEL  = 16'h0000;

  // Save command codes
  localparam logic [15:0] SAVE_STORE        = 16'h0001;
  localparam logic [15:0] SAVE_STORE_REBOOT = 16'h0002;
  localparam logic [15:0] SAVE_REBOOT       = 16'h0003;
  localparam logic [15:0] SAVE_DEFAULTS     = 16'h000a;

  // Command-type digit codes
  localparam logic [3:0] CMD_DUAL_PULSE = 4'h0;
  localparam logic [3:0] CMD_PULSE_DIR  = 4'h1;
  localparam logic [3:0] CMD_QUADRATURE = 4'h2;
  localparam logic [3:0] CMD_HOST       = 4'h8;

  // Mechanics digit field positions and limits
  localparam int          POS_LOAD    = 0;
  localparam int          POS_APP     = 4;
  localparam int          POS_LIMIT   = 8;
  localparam int          POS_POL     = 12;
  localparam logic [3:0]  MAX_LOAD    = 4'h2;
  localparam logic [3:0]  MAX_APP     = 4'h2;
  localparam logic [3:0]  MAX_FLAG    = 4'h1;
  localparam logic [3:0]  LOAD_BELT   = 4'h1;
  localparam logic [3:0]  LOAD_SCREW  = 4'h2;

  // Working mode, two's complement of -4
  localparam logic [7:0]  MODE_PULSE  = 8'hfc;

  // Display and tuning presets
  localparam logic [31:0] DEC_LIMIT       = 32'h0000_270f;
  localparam logic [4:0]  STIFF_BELT      = 5'h0a;
  localparam logic [4:0]  STIFF_SCREW     = 5'h0d;
  localparam logic [4:0]  STIFF_OTHER     = 5'h0a;
  localparam logic [15:0] INERTIA_BELT    = 16'h0032;
  localparam logic [15:0] INERTIA_SCREW   = 16'h001e;
  localparam logic [15:0] INERTIA_OTHER   = 16'h001e;
  localparam logic [4:0]  STIFF_MAX       = 5'h1f;
  localparam logic [15:0] TUNE_START_CODE = 16'h0001;

  // Menu timeout
  localparam int          MENU_TIMEOUT_S   = 30;
  localparam int          CLK_HZ           = 10_000_000;
  localparam logic [31:0] MENU_TIMEOUT_CYC = 32'(64'(MENU_TIMEOUT_S) * 64'(CLK_HZ));

  // Parameter write request
  typedef struct packed {
    logic        valid;
    logic [3:0]  index;
    logic [31:0] data;
  } param_wr_t;

  // Mapped input functions
  typedef struct packed {
    logic enable;
    logic clearErr;
    logic homing;
    logic posLimit;
    logic negLimit;
    logic homeSensor;
  } din_func_t;

endpackage : quick_setup_pkg

// ===== design/servo_quick_setup_menu.sv
// Quick-setup parameter menu with save, mapping, motor check and tuning presets
`timescale 1ns/1ns
module servo_quick_setup_menu #(
  parameter logic [31:0] TIMEOUT_CYCLES = quick_setup_pkg::MENU_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      clkEn,
  // Key panel
  input  wire logic                      keyPin,
  input  wire logic                      menuEnter,
  output logic                           menuActive,
  // Parameter port
  input  wire quick_setup_pkg::param_wr_t paramWr,
  input  wire logic [3:0]                rdIndex,
  output logic [31:0]                    rdData,
  output logic                           settingFail,
  // Drive state and motor identity
  input  wire logic                      driveEnabled,
  input  wire logic                      motorIdValid,
  input  wire logic [15:0]               motorId,
  // Digital input pins and drive status
  input  wire logic [6:0]                dinPins,
  input  wire logic [4:0]                statusIn,
  output quick_setup_pkg::din_func_t     dinFunc,
  output logic [4:0]                     doutPins,
  // Operating results
  output logic                           storeReq,
  output logic                           rebootReq,
  output logic                           loopRecalc,
  output logic                           modeForced,
  output logic [7:0]                     workMode,
  output logic                           gearActive,
  output logic [31:0]                    gearNum,
  output logic [31:0]                    gearDen,
  output logic                           gearNumHex,
  output logic                           gearDenHex,
  output logic                           limitDisabled,
  output logic                           displayFlash,
  output logic                           motorMismatch,
  output logic [4:0]                     stiffness,
  output logic [15:0]                    inertiaRatio,
  output logic                           tuneStart,
  output logic                           tuneEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // Live and stored parameters
  logic [15:0] cmdType_reg, mech_reg, homing_reg, motorModel_reg;
  logic [31:0] gearNum_reg, gearDen_reg;
  logic [15:0] cmdTypeSaved_reg, mechSaved_reg, homingSaved_reg, motorSaved_reg;
  logic [31:0] gearNumSaved_reg, gearDenSaved_reg;
  logic [3:0]  cmdDigit, loadDigit, appDigit;
  logic        pulseMode, wrOk, wrAccept, inRange;
  logic [15:0] wrData16;
  logic [4:0]  stiffPreset;
  logic [15:0] inertiaPreset;

  assign cmdDigit  = cmdType_reg[3:0];
  assign loadDigit = mech_reg[quick_setup_pkg::POS_LOAD +: 4];
  assign appDigit  = mech_reg[quick_setup_pkg::POS_APP +: 4];
  assign wrData16  = paramWr.data[15:0];
  // Pulse formats are the three low codes [RL5]
  assign pulseMode = (cmdDigit == quick_setup_pkg::CMD_DUAL_PULSE) ||
                     (cmdDigit == quick_setup_pkg::CMD_PULSE_DIR)  ||
                     (cmdDigit == quick_setup_pkg::CMD_QUADRATURE);

  ////////////////////////////////////////////////////////////////////////////
  // Range check of a write
  always_comb begin
    inRange = 1'b1;
    case (paramWr.index)
      quick_setup_pkg::IDX_COMMAND_TYPE: begin
        inRange = (wrData16[3:0] <= quick_setup_pkg::CMD_QUADRATURE) ||
                  (wrData16[3:0] == quick_setup_pkg::CMD_HOST); // [RL5] [RL18]
      end
      quick_setup_pkg::IDX_GEAR_NUMERATOR,
      quick_setup_pkg::IDX_GEAR_DENOMINATR: inRange = (paramWr.data != 32'h0000_0000); // [RL18]
      quick_setup_pkg::IDX_MECHANICS: begin
        inRange = (wrData16[quick_setup_pkg::POS_LOAD +: 4] <= quick_setup_pkg::MAX_LOAD) &&
                  (wrData16[quick_setup_pkg::POS_APP +: 4] <= quick_setup_pkg::MAX_APP) &&
                  (wrData16[quick_setup_pkg::POS_LIMIT +: 4] <= quick_setup_pkg::MAX_FLAG) &&
                  (wrData16[quick_setup_pkg::POS_POL +: 4] <= quick_setup_pkg::MAX_FLAG);
      end
      quick_setup_pkg::IDX_STIFFNESS: inRange = (paramWr.data <= 32'(quick_setup_pkg::STIFF_MAX));
      default:                        inRange = 1'b1;
    endcase
  end

  // Every write, commands included, needs a disabled drive
  assign wrOk     = inRange && !driveEnabled; // [RL18]
  assign wrAccept = paramWr.valid && wrOk;

  ////////////////////////////////////////////////////////////////////////////
  // Stiffness and inertia estimates from the load-type mechanics digit
  always_comb begin
    case (loadDigit)
      quick_setup_pkg::LOAD_BELT: begin
        stiffPreset   = quick_setup_pkg::STIFF_BELT;
        inertiaPreset = quick_setup_pkg::INERTIA_BELT;
      end
      quick_setup_pkg::LOAD_SCREW: begin
        stiffPreset   = quick_setup_pkg::STIFF_SCREW;
        inertiaPreset = quick_setup_pkg::INERTIA_SCREW;
      end
      default: begin
        stiffPreset   = quick_setup_pkg::STIFF_OTHER;
        inertiaPreset = quick_setup_pkg::INERTIA_OTHER;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] keySync_reg;
  logic       keyPrev_reg;
  logic [6:0] dinMeta_reg, din_reg;
  logic       keyEvent;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      keySync_reg <= 2'h0;
      keyPrev_reg <= 1'b0;
      dinMeta_reg <= 7'h00;
      din_reg     <= 7'h00;
    end else if (clkEn) begin
      keySync_reg <= {keySync_reg[0], keyPin};
      keyPrev_reg <= keySync_reg[1];
      dinMeta_reg <= dinPins;
      din_reg     <= dinMeta_reg;
    end
  end

  assign keyEvent = keySync_reg[1] && !keyPrev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Menu session with inactivity timeout
  logic [31:0] idleCnt_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      menuActive  <= 1'b0;
      idleCnt_reg <= 32'h0000_0000;
    end else if (clkEn) begin
      if (menuEnter) begin
        menuActive  <= 1'b1;
        idleCnt_reg <= 32'h0000_0000;
      end else if (menuActive) begin
        if (keyEvent) begin
          idleCnt_reg <= 32'h0000_0000;
        end else if (idleCnt_reg >= TIMEOUT_CYCLES - 32'h0000_0001) begin
          menuActive  <= 1'b0; // [RL1]
          idleCnt_reg <= 32'h0000_0000;
        end else begin
          idleCnt_reg <= idleCnt_reg + 32'h0000_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter writes, save command and defaults
  logic saveHit, defaultsHit, storeHit, tuneHit;

  assign saveHit     = wrAccept && (paramWr.index == quick_setup_pkg::IDX_SAVE_COMMAND);
  assign defaultsHit = saveHit && (wrData16 == quick_setup_pkg::SAVE_DEFAULTS);
  assign storeHit    = saveHit && (wrData16 == quick_setup_pkg::SAVE_STORE ||
                                   wrData16 == quick_setup_pkg::SAVE_STORE_REBOOT);
  assign tuneHit     = wrAccept && (paramWr.index == quick_setup_pkg::IDX_TUNING_METHOD) &&
                       (wrData16 == quick_setup_pkg::TUNE_START_CODE);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmdType_reg <= quick_setup_pkg::RST_COMMAND_TYPE;
      gearNum_reg <= quick_setup_pkg::RST_GEAR;
      gearDen_reg <= quick_setup_pkg::RST_GEAR;
      mech_reg    <= quick_setup_pkg::RST_MECHANICS;
      homing_reg  <= quick_setup_pkg::RST_HOMING;
    end else if (clkEn) begin
      if (defaultsHit) begin
        cmdType_reg <= quick_setup_pkg::RST_COMMAND_TYPE; // [RL3]
        gearNum_reg <= quick_setup_pkg::RST_GEAR;
        gearDen_reg <= quick_setup_pkg::RST_GEAR;
        mech_reg    <= quick_setup_pkg::RST_MECHANICS;
        homing_reg  <= quick_setup_pkg::RST_HOMING;
      end else if (wrAccept) begin
        // Values act immediately [RL2]
        case (paramWr.index)
          quick_setup_pkg::IDX_COMMAND_TYPE:    cmdType_reg <= wrData16;
          quick_setup_pkg::IDX_GEAR_NUMERATOR:  gearNum_reg <= paramWr.data;
          quick_setup_pkg::IDX_GEAR_DENOMINATR: gearDen_reg <= paramWr.data;
          quick_setup_pkg::IDX_MECHANICS:       mech_reg    <= wrData16; // [RL12] [RL13]
          quick_setup_pkg::IDX_HOMING_METHOD:   homing_reg  <= wrData16;
          default: ;
        endcase
      end
    end
  end

  // Persistent copies follow the live values only on a store code
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmdTypeSaved_reg <= quick_setup_pkg::RST_COMMAND_TYPE;
      gearNumSaved_reg <= quick_setup_pkg::RST_GEAR;
      gearDenSaved_reg <= quick_setup_pkg::RST_GEAR;
      mechSaved_reg    <= quick_setup_pkg::RST_MECHANICS;
      homingSaved_reg  <= quick_setup_pkg::RST_HOMING;
      motorSaved_reg   <= quick_setup_pkg::RST_MOTOR_MODEL;
    end else if (clkEn && storeHit) begin
      cmdTypeSaved_reg <= cmdType_reg; // [RL2] [RL3]
      gearNumSaved_reg <= gearNum_reg;
      gearDenSaved_reg <= gearDen_reg;
      mechSaved_reg    <= mech_reg;
      homingSaved_reg  <= homing_reg;
      motorSaved_reg   <= motorModel_reg;
    end
  end

  // Command pulses of the save parameter; other codes do nothing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      storeReq    <= 1'b0;
      rebootReq   <= 1'b0;
      loopRecalc  <= 1'b0;
      settingFail <= 1'b0;
    end else if (clkEn) begin
      storeReq    <= storeHit; // [RL3]
      rebootReq   <= saveHit && (wrData16 == quick_setup_pkg::SAVE_STORE_REBOOT ||
                                 wrData16 == quick_setup_pkg::SAVE_REBOOT); // [RL3] [RL20]
      loopRecalc  <= storeHit; // [RL4]
      settingFail <= paramWr.valid && !wrOk; // [RL18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tuning presets, direct inertia entry and measurement start
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stiffness    <= quick_setup_pkg::STIFF_OTHER;
      inertiaRatio <= quick_setup_pkg::INERTIA_OTHER;
      tuneStart    <= 1'b0;
      tuneEnable   <= 1'b0;
    end else if (clkEn) begin
      tuneStart <= tuneHit; // [RL19]
      if (tuneHit) begin
        tuneEnable <= 1'b1; // [RL19]
      end else if (keyEvent) begin
        tuneEnable <= 1'b0;
      end
      if (storeHit) begin
        stiffness    <= stiffPreset; // [RL16] [RL4]
        inertiaRatio <= inertiaPreset;
      end else if (wrAccept && paramWr.index == quick_setup_pkg::IDX_INERTIA_RATIO) begin
        inertiaRatio <= wrData16; // [RL17]
      end else if (wrAccept && paramWr.index == quick_setup_pkg::IDX_STIFFNESS) begin
        stiffness <= paramWr.data[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motor identity learning and mismatch check
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      motorModel_reg <= quick_setup_pkg::RST_MOTOR_MODEL;
      motorMismatch  <= 1'b0;
      displayFlash   <= 1'b0;
    end else if (clkEn) begin
      if (motorIdValid && motorSaved_reg == quick_setup_pkg::RST_MOTOR_MODEL) begin
        motorModel_reg <= motorId; // [RL10]
      end
      // Fresh drive with no identity seen keeps flashing
      if (motorSaved_reg != quick_setup_pkg::RST_MOTOR_MODEL) begin
        motorMismatch <= motorIdValid && (motorId != motorSaved_reg); // [RL11]
        displayFlash  <= motorIdValid && (motorId != motorSaved_reg); // [RL11]
      end else begin
        motorMismatch <= 1'b0;
        displayFlash  <= !motorIdValid; // [RL10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, gear, display format and input/output mapping
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      modeForced    <= 1'b1;
      workMode      <= quick_setup_pkg::MODE_PULSE;
      gearActive    <= 1'b1;
      gearNum       <= quick_setup_pkg::RST_GEAR;
      gearDen       <= quick_setup_pkg::RST_GEAR;
      gearNumHex    <= 1'b0;
      gearDenHex    <= 1'b0;
      limitDisabled <= 1'b0;
      dinFunc       <= '0;
      doutPins      <= 5'h00;
    end else if (clkEn) begin
      modeForced    <= pulseMode; // [RL6]
      workMode      <= pulseMode ? quick_setup_pkg::MODE_PULSE : workMode;
      gearActive    <= pulseMode; // [RL8]
      gearNum       <= pulseMode ? gearNum_reg : 32'h0000_0001;
      gearDen       <= pulseMode ? gearDen_reg : 32'h0000_0001;
      gearNumHex    <= (gearNum_reg > quick_setup_pkg::DEC_LIMIT); // [RL9]
      gearDenHex    <= (gearDen_reg > quick_setup_pkg::DEC_LIMIT); // [RL9]
      limitDisabled <= mech_reg[quick_setup_pkg::POS_LIMIT]; // [RL13]
      // Inputs one to three lose their functions in host mode [RL7] [RL14]
      dinFunc.enable     <= pulseMode && din_reg[0];
      dinFunc.clearErr   <= pulseMode && din_reg[1];
      dinFunc.homing     <= pulseMode && din_reg[2];
      dinFunc.posLimit   <= din_reg[3] && !mech_reg[quick_setup_pkg::POS_LIMIT];
      dinFunc.negLimit   <= din_reg[4] && !mech_reg[quick_setup_pkg::POS_LIMIT];
      dinFunc.homeSensor <= din_reg[6];
      // Ready, brake, reached, zero speed, error; error polarity selectable [RL15]
      doutPins <= {statusIn[4] ^ !mech_reg[quick_setup_pkg::POS_POL], statusIn[3:0]}; // [RL13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter read-back
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdData <= 32'h0000_0000;
    end else if (clkEn) begin
      case (rdIndex)
        quick_setup_pkg::IDX_MOTOR_MODEL:     rdData <= {16'h0000, motorModel_reg};
        quick_setup_pkg::IDX_COMMAND_TYPE:    rdData <= {16'h0000, cmdType_reg};
        quick_setup_pkg::IDX_GEAR_NUMERATOR:  rdData <= gearNum_reg;
        quick_setup_pkg::IDX_GEAR_DENOMINATR: rdData <= gearDen_reg;
        quick_setup_pkg::IDX_MECHANICS:       rdData <= {16'h0000, mech_reg};
        quick_setup_pkg::IDX_HOMING_METHOD:   rdData <= {16'h0000, homing_reg};
        quick_setup_pkg::IDX_INERTIA_RATIO:   rdData <= {16'h0000, inertiaRatio};
        quick_setup_pkg::IDX_STIFFNESS:       rdData <= {27'h0000000, stiffness};
        default:                              rdData <= 32'h0000_0000;
      endcase
    end
  end

endmodule : servo_quick_setup_menu

// ===== verif/quick_setup_props.sv
// Port checker of the quick-setup parameter menu
`timescale 1ns/1ns
module quick_setup_props #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'h0000_0014
) (
  // Clock and control
  input wire logic                       clk_sys,
  input wire logic                       resetn,
  input wire logic                       clkEn,
  // Requests
  input wire logic                       keyPin,
  input wire logic                       menuEnter,
  input wire quick_setup_pkg::param_wr_t paramWr,
  input wire logic                       driveEnabled,
  input wire logic [4:0]                 statusIn,
  // Results
  input wire logic                       menuActive,
  input wire logic                       settingFail,
  input wire quick_setup_pkg::din_func_t dinFunc,
  input wire logic [4:0]                 doutPins,
  input wire logic                       storeReq,
  input wire logic                       rebootReq,
  input wire logic                       loopRecalc,
  input wire logic                       gearActive,
  input wire logic                       gearNumHex,
  input wire logic [31:0]                gearNum
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [31:0] idleCnt;
  logic        saveWr;
  // Accepted write to the save command
  assign saveWr = clkEn && paramWr.valid && paramWr.index == 4'h0 && !driveEnabled;
  // Cycles since the last key activity or menu entry
  always_ff @(posedge clk_sys) begin
    if (!resetn || menuEnter || keyPin) begin
      idleCnt <= 32'h0;
    end else if (clkEn && idleCnt < 32'hffff_fff0) begin
      idleCnt <= idleCnt + 32'h1;
    end
  end
  property p_idle; idleCnt > TIMEOUT_CYCLES + 32'h4 |-> !menuActive; endproperty
  a_idle: assert property (p_idle) else $error("menu open after idle limit");
  property p_store; saveWr && paramWr.data[15:0] == 16'h1 |=> storeReq && loopRecalc && !rebootReq;
  endproperty
  a_store: assert property (p_store) else $error("store code not acted on");
  property p_ignore;
    saveWr && !(paramWr.data[15:0] inside {16'h1, 16'h2, 16'h3, 16'ha})
      |=> !storeReq && !rebootReq && !settingFail;
  endproperty
  a_ignore: assert property (p_ignore) else $error("undefined save code acted");
  property p_reject; clkEn && paramWr.valid && driveEnabled |=> settingFail; endproperty
  a_reject: assert property (p_reject) else $error("write while enabled kept");
  property p_host;
    clkEn && paramWr.valid && paramWr.index == 4'h2 && paramWr.data == 32'h8 && !driveEnabled
      |-> ##[1:2] !gearActive;
  endproperty
  a_host: assert property (p_host) else $error("host type keeps gear");
  property p_hex;
    gearActive && $stable(gearNum) |-> gearNumHex == (gearNum > 32'h0000_270f);
  endproperty
  a_hex: assert property (p_hex) else $error("gear display base wrong");
  property p_status; clkEn |=> ((doutPins ^ $past(statusIn)) & 5'h0f) == 5'h00; endproperty
  a_status: assert property (p_status) else $error("output pins not mapped");
  property p_hostDin;
    !gearActive [*4] |-> !dinFunc.enable && !dinFunc.clearErr && !dinFunc.homing;
  endproperty
  a_hostDin: assert property (p_hostDin) else $error("host mode input active");
endmodule : quick_setup_props
bind servo_quick_setup_menu quick_setup_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.*);

// ===== verif/panel_operator.sv
// Key panel operator: holds the key for a few cycles per press
`timescale 1ns/1ns
module panel_operator (
  // Clock and request
  input  wire logic clk_sys,
  input  wire logic pressReq,
  // Key pin
  output logic      keyPin
);
  int holdCnt = 0;
  // A finger stays on the key three cycles, moving only at falling edges
  always @(negedge clk_sys) begin
    if (pressReq) begin
      holdCnt <= 3;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
  assign keyPin = (holdCnt > 0);
endmodule : panel_operator

// ===== verif/tb.sv
// Self-checking testbench of the quick-setup parameter menu
`timescale 1ns/1ns
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errCount++; \
  $display("MISMATCH %0t line %0d", $time, `__LINE__); end end
module tb;
  int errCount = 0;
  int nChecks = 0;
  int n;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic menuEnter = 1'b0;
  logic pressReq = 1'b0;
  logic driveEnabled = 1'b0;
  logic motorIdValid = 1'b1;
  logic [15:0] motorId = 16'h1234;
  logic [6:0] dinPins = 7'h7f;
  logic [4:0] statusIn = 5'h15;
  logic [3:0] rdIndex = 4'h0;
  quick_setup_pkg::param_wr_t paramWr = '0;
  logic keyPin, menuActive, settingFail, storeReq, rebootReq, loopRecalc, modeForced;
  logic gearActive, gearNumHex, gearDenHex, limitDisabled, displayFlash, motorMismatch;
  logic tuneStart, tuneEnable, fail, store, reboot, recalc, tune;
  logic [31:0] rdData, gearNum, gearDen;
  logic [15:0] inertiaRatio;
  logic [7:0] workMode;
  logic [4:0] doutPins, stiffness;
  quick_setup_pkg::din_func_t dinFunc;
  logic [3:0] cmds [4] = '{4'h0, 4'h1, 4'h2, 4'h8};
  servo_quick_setup_menu #(.TIMEOUT_CYCLES(32'h14)) u_dut (.*);
  panel_operator u_op (.clk_sys(clk_sys), .pressReq(pressReq), .keyPin(keyPin));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  // One write request; result pulses are captured in the cycle after
  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    @(negedge clk_sys);
    paramWr <= {1'b1, idx, d};
    @(negedge clk_sys);
    paramWr.valid <= 1'b0;
    {fail, store, reboot, recalc, tune} = {settingFail, storeReq, rebootReq, loopRecalc, tuneStart};
    @(negedge clk_sys);
  endtask : wr
  // One read, data one cycle after the index
  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    @(negedge clk_sys);
    rdIndex <= idx;
    @(negedge clk_sys);
    `CHK(rdData, exp)
  endtask : rd
  task automatic printVerdict();
    if (errCount == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : printVerdict
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_sys);
    resetn <= 1'b1;
    rd(4'h2, 32'h1);
    rd(4'h6, 32'h1001);
    rd(4'h1, 32'h1234);
    motorIdValid <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(displayFlash, 1'b1)
    motorIdValid <= 1'b1;
    menuEnter <= 1'b1;
    @(negedge clk_sys);
    menuEnter <= 1'b0;
    `CHK(menuActive, 1'b1)
    repeat (15) @(negedge clk_sys);
    pressReq <= 1'b1;
    @(negedge clk_sys);
    pressReq <= 1'b0;
    repeat (15) @(negedge clk_sys);
    `CHK(menuActive, 1'b1)
    for (n = 0; n < 40 && menuActive === 1'b1; n++) @(negedge clk_sys);
    `CHK(n > 0 && n < 12, 1'b1)
    wr(4'h3, 32'h2710);
    `CHK({gearNumHex, gearNum}, {1'b1, 32'h2710})
    wr(4'h3, 32'h270f);
    `CHK(gearNumHex, 1'b0)
    wr(4'h4, 32'h0);
    `CHK({fail, gearDen, gearDenHex}, {1'b1, 32'h3e8, 1'b0})
    foreach (cmds[i]) begin
      wr(4'h2, {28'h0, cmds[i]});
      rd(4'h2, {28'h0, cmds[i]});
      `CHK({modeForced, gearActive}, {2{cmds[i] != 4'h8}})
      `CHK(gearNum, (cmds[i] == 4'h8) ? 32'h1 : 32'h270f)
      if (cmds[i] != 4'h8) `CHK(workMode, 8'hfc)
    end
    repeat (3) @(negedge clk_sys);
    `CHK(dinFunc, 6'h07)
    wr(4'h2, 32'h1);
    repeat (3) @(negedge clk_sys);
    `CHK(dinFunc, 6'h3f)
    dinPins <= 7'h41;
    repeat (4) @(negedge clk_sys);
    `CHK(dinFunc, 6'h21)
    wr(4'h6, 32'h0012);
    wr(4'h0, 32'h1);
    `CHK({store, recalc, reboot, stiffness, inertiaRatio}, {3'b110, 5'h0d, 16'h1e})
    wr(4'h6, 32'h1101);
    `CHK({limitDisabled, doutPins}, {1'b1, statusIn})
    wr(4'h0, 32'h2);
    `CHK({store, reboot, stiffness, inertiaRatio}, {2'b11, 5'h0a, 16'h32})
    wr(4'h6, 32'h0001);
    `CHK({limitDisabled, doutPins}, {1'b0, statusIn ^ 5'h10})
    wr(4'h0, 32'h3);
    `CHK({store, reboot}, 2'b01)
    wr(4'h0, 32'h5);
    `CHK({fail, store, reboot}, 3'b000)
    wr(4'h2, 32'h0);
    wr(4'h7, 32'h23);
    rd(4'h7, 32'h23);
    wr(4'h0, 32'ha);
    rd(4'h2, 32'h1);
    rd(4'h7, 32'h0);
    rd(4'h6, 32'h1001);
    driveEnabled <= 1'b1;
    wr(4'h3, 32'h5);
    `CHK(fail, 1'b1)
    driveEnabled <= 1'b0;
    clkEn <= 1'b0;
    wr(4'h3, 32'h5);
    `CHK(fail, 1'b0)
    clkEn <= 1'b1;
    rd(4'h3, 32'h3e8);
    wr(4'h9, 32'h28);
    `CHK(inertiaRatio, 16'h28)
    wr(4'hb, 32'h20);
    `CHK(fail, 1'b1)
    wr(4'ha, 32'h1);
    `CHK({tune, tuneEnable}, 2'b11)
    motorId <= 16'h5678;
    repeat (3) @(negedge clk_sys);
    `CHK(motorMismatch, 1'b1)
    printVerdict();
  end
endmodule : tb
